// ==== design/csc_event_and_coef_regs.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Blue luma weight held in its own 16.16 register, value times 65536.
// - Red-difference compression coefficient held in its own 16.16 register.
// - Blue-difference compression coefficient held in its own 16.16 register.
// - Framing errors, frame start and frame end always detected.
// - Interrupt pin only live when the control port is built.
// - Interrupt is a level while any enabled status flag is set.
// - Status flags stay set until software writes one to them.
// - Optional parallel event vector exposes each source separately.
// - Parallel event bits follow the event, they do not latch.
// - Vector bits: start, done, two reserved, stream error, line/frame errors.
// - RGB converted to YCrCb 4:4:4, one output pixel per input pixel.
// - Stream in and out follow the AXI4-Stream video handshake.
// - Optional AXI4-Lite slave gives software access to registers.
// - Image size, pixel rate and frame rate pass through unchanged.
// - Interrupt is OR over status bits ANDed with enable bits.
// - Status bit 0 frame begun, bit 1 frame done, bit 16 error.
// - Short or long lines set sticky error flags, cleared by writing one.
module csc_event_and_coef_regs
  import csc_pkg::*;
#(
  parameter bit HAS_CTRL_PORT  = 1'b1,
  parameter bit HAS_EVENT_PORT = 1'b1
) (
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic [CSC_AW-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [CSC_AW-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [CSC_PIX_W-1:0] s_axis_tdata,
  input  wire logic                 s_axis_tvalid,
  output logic                      s_axis_tready,
  input  wire logic                 s_axis_tuser,
  input  wire logic                 s_axis_tlast,
  output logic [CSC_PIX_W-1:0]      m_axis_tdata,
  output logic                      m_axis_tvalid,
  input  wire logic                 m_axis_tready,
  output logic                      m_axis_tuser,
  output logic                      m_axis_tlast,
  input  wire logic [31:0]          red_weight_coef,
  input  wire logic [7:0]           luma_offset,
  input  wire logic [7:0]           red_diff_offset,
  input  wire logic [7:0]           blue_diff_offset,
  input  wire logic [CSC_DIM_W-1:0] active_width,
  input  wire logic [CSC_DIM_W-1:0] active_height,
  output logic                      irq,
  output logic [CSC_EVT_W-1:0]      parallel_event_vector
);

  function automatic csc_sel_t csc_decode(input logic [CSC_AW-1:0] addr);
    unique case (addr)
      CSC_STATUS_OFF: csc_decode = CSC_SEL_STATUS;
      CSC_ERROR_OFF:  csc_decode = CSC_SEL_ERROR;
      CSC_IRQ_EN_OFF: csc_decode = CSC_SEL_IRQ_EN;
      CSC_BLUE_WEIGHT_COEF_REG_OFF:  csc_decode = CSC_SEL_BLUE_WEIGHT_COEF_REG;
      CSC_RED_DIFF_SCALE_COEF_REG_OFF:  csc_decode = CSC_SEL_RED_DIFF_SCALE_COEF_REG;
      CSC_BLUE_DIFF_SCALE_COEF_REG_OFF:  csc_decode = CSC_SEL_BLUE_DIFF_SCALE_COEF_REG;
      default:        csc_decode = CSC_SEL_NONE;
    endcase
  endfunction : csc_decode

  function automatic logic [31:0] csc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      csc_merge[8*i +: 8] = strb[i] ? new_v[8*i +: 8] : old_v[8*i +: 8];
    end
  endfunction : csc_merge

  function automatic logic [7:0] csc_clip(input logic signed [63:0] v);
    if (v < 0)
      csc_clip = 8'h00;
    else if (v > $signed({56'h0, CSC_PIX_MAX}))
      csc_clip = CSC_PIX_MAX;
    else
      csc_clip = v[7:0];
  endfunction : csc_clip

  logic [31:0]          blue_weight_coef_reg;
  logic [31:0]          red_diff_scale_coef_reg;
  logic [31:0]          blue_diff_scale_coef_reg;
  logic [31:0]          status_reg;
  logic [3:0]           error_reg;
  logic [31:0]          irq_enable_reg;
  logic                 wr_fire;
  logic                 rd_fire;
  csc_sel_t             wr_sel;
  logic [31:0]          wr_mask;
  logic [31:0]          rd_word;
  logic                 frame_start;
  logic                 frame_done;
  logic                 line_end_short_flag;
  logic                 line_end_long_flag;
  logic                 sof_early;
  logic                 sof_late;
  logic                 any_error;
  logic                 accept;
  logic [CSC_PIX_W+1:0] next_pix;
  logic [CSC_PIX_W+1:0] skid;
  logic                 skid_valid;

  // Address and data are taken together, one write in flight at a time
  assign wr_fire = HAS_CTRL_PORT && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                   && !s_axi_awready;
  assign rd_fire = HAS_CTRL_PORT && s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  assign wr_sel  = csc_decode(s_axi_awaddr);
  assign wr_mask = csc_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= CSC_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == CSC_SEL_NONE) ? CSC_RESP_SLVERR : CSC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (csc_decode(s_axi_araddr))
      CSC_SEL_STATUS: rd_word = status_reg;
      CSC_SEL_ERROR:  rd_word = {28'h0, error_reg};
      CSC_SEL_IRQ_EN: rd_word = irq_enable_reg;
      CSC_SEL_BLUE_WEIGHT_COEF_REG:  rd_word = blue_weight_coef_reg;
      CSC_SEL_RED_DIFF_SCALE_COEF_REG:  rd_word = red_diff_scale_coef_reg;
      CSC_SEL_BLUE_DIFF_SCALE_COEF_REG:  rd_word = blue_diff_scale_coef_reg;
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= CSC_WORD_RST;
      s_axi_rresp   <= CSC_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= (csc_decode(s_axi_araddr) == CSC_SEL_NONE) ? CSC_RESP_SLVERR
                                                                     : CSC_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Coefficients, byte lanes honoured
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blue_weight_coef_reg     <= CSC_COEF_RST;
      red_diff_scale_coef_reg  <= CSC_COEF_RST;
      blue_diff_scale_coef_reg <= CSC_COEF_RST;
      irq_enable_reg           <= CSC_WORD_RST;
    end else if (wr_fire) begin
      if (wr_sel == CSC_SEL_BLUE_WEIGHT_COEF_REG)
        blue_weight_coef_reg <= csc_merge(blue_weight_coef_reg, s_axi_wdata, s_axi_wstrb);
      if (wr_sel == CSC_SEL_RED_DIFF_SCALE_COEF_REG)
        red_diff_scale_coef_reg <= csc_merge(red_diff_scale_coef_reg, s_axi_wdata,
                                             s_axi_wstrb);
      if (wr_sel == CSC_SEL_BLUE_DIFF_SCALE_COEF_REG)
        blue_diff_scale_coef_reg <= csc_merge(blue_diff_scale_coef_reg, s_axi_wdata,
                                              s_axi_wstrb);
      if (wr_sel == CSC_SEL_IRQ_EN)
        irq_enable_reg <= csc_merge(irq_enable_reg, s_axi_wdata, s_axi_wstrb);
    end
  end

  csc_frame_check u_frame_check (
    .mclk          (mclk),
    .resetn        (resetn),
    .beat          (accept),
    .sof           (s_axis_tuser),
    .eol           (s_axis_tlast),
    .active_width  (active_width),
    .active_height (active_height),
    .frame_start   (frame_start),
    .frame_done    (frame_done),
    .line_end_short_flag     (line_end_short_flag),
    .line_end_long_flag      (line_end_long_flag),
    .sof_early     (sof_early),
    .sof_late      (sof_late)
  );

  assign any_error = line_end_short_flag | line_end_long_flag | sof_early | sof_late;

  // Sticky flags: a new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= CSC_WORD_RST;
      error_reg  <= 4'h0;
    end else begin
      status_reg <= (status_reg & ~((wr_fire && wr_sel == CSC_SEL_STATUS) ? wr_mask : 32'h0))
                    | ({31'h0, frame_start} << CSC_ST_BEGUN)
                    | ({31'h0, frame_done} << CSC_ST_DONE)
                    | ({31'h0, any_error} << CSC_ST_ERROR);
      error_reg  <= (error_reg & ~((wr_fire && wr_sel == CSC_SEL_ERROR) ? wr_mask[3:0] : 4'h0))
                    | {sof_late, sof_early, line_end_long_flag, line_end_short_flag};
    end
  end

  // Pin stays low when the control port is not built
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= HAS_CTRL_PORT && |(status_reg & irq_enable_reg);
  end

  // One cycle per event; a downstream collector should catch the edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      parallel_event_vector <= '0;
    end else if (HAS_EVENT_PORT) begin
      parallel_event_vector <= '0;
      parallel_event_vector[CSC_EV_START]    <= frame_start;
      parallel_event_vector[CSC_EV_DONE]     <= frame_done;
      parallel_event_vector[CSC_EV_STREAM]   <= any_error;
      parallel_event_vector[CSC_EV_EOL_ERLY] <= line_end_short_flag;
      parallel_event_vector[CSC_EV_LINE_END_LONG_FLAG] <= line_end_long_flag;
      parallel_event_vector[CSC_EV_SOF_ERLY] <= sof_early;
      parallel_event_vector[CSC_EV_SOF_LATE] <= sof_late;
    end
  end

  // Conversion in Q16: Y = G + CA(R-G) + CB(B-G), Cr = CC(R-Y), Cb = CD(B-Y)
  always_comb begin
    logic signed [63:0] r_q;
    logic signed [63:0] g_q;
    logic signed [63:0] b_q;
    logic signed [63:0] y_q;
    logic signed [63:0] cr_q;
    logic signed [63:0] cb_q;
    r_q  = $signed({40'h0, s_axis_tdata[23:16], 16'h0});
    g_q  = $signed({40'h0, s_axis_tdata[7:0], 16'h0});
    b_q  = $signed({40'h0, s_axis_tdata[15:8], 16'h0});
    y_q  = g_q
           + (($signed({{32{red_weight_coef[31]}}, red_weight_coef}) * (r_q - g_q))
              >>> CSC_FRAC_BITS)
           + (($signed({{32{blue_weight_coef_reg[31]}}, blue_weight_coef_reg}) * (b_q - g_q))
              >>> CSC_FRAC_BITS);
    cr_q = ($signed({{32{red_diff_scale_coef_reg[31]}}, red_diff_scale_coef_reg}) * (r_q - y_q))
           >>> CSC_FRAC_BITS;
    cb_q = ($signed({{32{blue_diff_scale_coef_reg[31]}}, blue_diff_scale_coef_reg})
            * (b_q - y_q)) >>> CSC_FRAC_BITS;
    next_pix = {s_axis_tuser, s_axis_tlast,
                csc_clip(((cr_q + $signed(CSC_ROUND_HALF)) >>> CSC_FRAC_BITS)
                         + $signed({56'h0, red_diff_offset})),
                csc_clip(((cb_q + $signed(CSC_ROUND_HALF)) >>> CSC_FRAC_BITS)
                         + $signed({56'h0, blue_diff_offset})),
                csc_clip(((y_q + $signed(CSC_ROUND_HALF)) >>> CSC_FRAC_BITS)
                         + $signed({56'h0, luma_offset}))};
  end

  assign accept = s_axis_tvalid && s_axis_tready;

  // Skid slot keeps tready a flop output without losing a beat
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      m_axis_tvalid <= 1'b0;
      m_axis_tdata  <= '0;
      m_axis_tuser  <= 1'b0;
      m_axis_tlast  <= 1'b0;
      skid          <= '0;
      skid_valid    <= 1'b0;
      s_axis_tready <= 1'b0;
    end else begin
      if (m_axis_tready || !m_axis_tvalid) begin
        if (skid_valid) begin
          {m_axis_tuser, m_axis_tlast, m_axis_tdata} <= skid;
          m_axis_tvalid <= 1'b1;
          skid_valid    <= 1'b0;
          s_axis_tready <= 1'b1;
        end else begin
          {m_axis_tuser, m_axis_tlast, m_axis_tdata} <= next_pix;
          m_axis_tvalid <= accept;
          s_axis_tready <= 1'b1;
        end
      end else if (accept) begin
        skid          <= next_pix;
        skid_valid    <= 1'b1;
        s_axis_tready <= 1'b0;
      end
    end
  end

endmodule : csc_event_and_coef_regs

// ==== design/csc_frame_check.sv ====
`timescale 1ns/1ps
module csc_frame_check
  import csc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 beat,
  input  wire logic                 sof,
  input  wire logic                 eol,
  input  wire logic [CSC_DIM_W-1:0] active_width,
  input  wire logic [CSC_DIM_W-1:0] active_height,
  output logic                      frame_start,
  output logic                      frame_done,
  output logic                      line_end_short_flag,
  output logic                      line_end_long_flag,
  output logic                      sof_early,
  output logic                      sof_late
);

  logic [CSC_DIM_W-1:0] pix_cnt;
  logic [CSC_DIM_W-1:0] line_cnt;
  logic [CSC_DIM_W-1:0] pix_now;
  logic [CSC_DIM_W-1:0] line_now;

  // A start-of-frame beat is pixel 0 of line 0
  assign pix_now  = sof ? '0 : pix_cnt;
  assign line_now = sof ? '0 : line_cnt;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pix_cnt  <= '0;
      line_cnt <= '0;
    end else if (beat) begin
      if (eol) begin
        pix_cnt  <= '0;
        line_cnt <= line_now + 13'h0001;
      end else begin
        pix_cnt  <= pix_now + 13'h0001;
        line_cnt <= line_now; // A start beat restarts the line count too
      end
    end
  end

  // Each error fires once: a long line at the first beat past the width unless that beat carries eol, the others on their sof or eol beat
  always_comb begin
    frame_start = beat && sof;
    frame_done  = beat && eol && (line_now + 13'h0001 == active_height);
    line_end_short_flag   = beat && eol && (pix_now + 13'h0001 < active_width);
    line_end_long_flag    = beat && !eol && (pix_now == active_width);
    sof_early   = beat && sof && (line_cnt != '0) && (line_cnt < active_height);
    sof_late    = beat && eol && (line_now == active_height);
  end

endmodule : csc_frame_check

// ==== design/csc_pkg.sv ====
package csc_pkg;

  localparam int          CSC_AW          = 9;
  localparam int          CSC_PIX_W       = 24;
  localparam int          CSC_DIM_W       = 13;
  localparam int          CSC_EVT_W       = 9;

  localparam logic [8:0]  CSC_STATUS_OFF  = 9'h004;
  localparam logic [8:0]  CSC_ERROR_OFF   = 9'h008;
  localparam logic [8:0]  CSC_IRQ_EN_OFF  = 9'h00C;
  localparam logic [8:0]  CSC_BLUE_WEIGHT_COEF_REG_OFF   = 9'h128;
  localparam logic [8:0]  CSC_RED_DIFF_SCALE_COEF_REG_OFF   = 9'h12C;
  localparam logic [8:0]  CSC_BLUE_DIFF_SCALE_COEF_REG_OFF   = 9'h130;

  localparam int          CSC_ST_BEGUN    = 0;
  localparam int          CSC_ST_DONE     = 1;
  localparam int          CSC_ST_ERROR    = 16;
  localparam int          CSC_ER_EOL_ERLY = 0;
  localparam int          CSC_ER_LINE_END_LONG_FLAG = 1;
  localparam int          CSC_ER_SOF_ERLY = 2;
  localparam int          CSC_ER_SOF_LATE = 3;

  localparam int          CSC_EV_START    = 0;
  localparam int          CSC_EV_DONE     = 1;
  localparam int          CSC_EV_STREAM   = 4;
  localparam int          CSC_EV_EOL_ERLY = 5;
  localparam int          CSC_EV_LINE_END_LONG_FLAG = 6;
  localparam int          CSC_EV_SOF_ERLY = 7;
  localparam int          CSC_EV_SOF_LATE = 8;

  localparam logic [31:0] CSC_COEF_RST    = 32'h0000_0000;
  localparam logic [31:0] CSC_WORD_RST    = 32'h0000_0000;
  localparam logic [63:0] CSC_ROUND_HALF  = 64'h0000_0000_0000_8000;
  localparam int          CSC_FRAC_BITS   = 16;
  localparam logic [7:0]  CSC_PIX_MAX     = 8'hFF;

  localparam logic [1:0]  CSC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CSC_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CSC_SEL_NONE   = 3'b000,
    CSC_SEL_STATUS = 3'b001,
    CSC_SEL_ERROR  = 3'b010,
    CSC_SEL_IRQ_EN = 3'b011,
    CSC_SEL_BLUE_WEIGHT_COEF_REG  = 3'b100,
    CSC_SEL_RED_DIFF_SCALE_COEF_REG  = 3'b101,
    CSC_SEL_BLUE_DIFF_SCALE_COEF_REG  = 3'b110
  } csc_sel_t;

endpackage : csc_pkg

// ==== verif/csc_event_and_coef_regs_test.sv ====
`timescale 1ns/1ps
module csc_event_and_coef_regs_test;
  import csc_pkg::*;
  logic                 mclk, resetn, slow, irq;
  logic                 s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic                 s_axis_tvalid, s_axis_tuser, s_axis_tlast, s_axis_tready;
  logic                 m_axis_tvalid, m_axis_tready, m_axis_tuser, m_axis_tlast;
  logic [CSC_AW-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]          s_axi_wdata, s_axi_rdata, red_weight_coef;
  logic [3:0]           s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic [CSC_PIX_W-1:0] s_axis_tdata, m_axis_tdata, last_px;
  logic [7:0]           luma_offset, red_diff_offset, blue_diff_offset;
  logic [CSC_DIM_W-1:0] active_width, active_height;
  logic [CSC_EVT_W-1:0] parallel_event_vector;
  logic [15:0]          n_beats;
  logic [8:0]           coef_a[3] = '{CSC_BLUE_WEIGHT_COEF_REG_OFF, CSC_RED_DIFF_SCALE_COEF_REG_OFF, CSC_BLUE_DIFF_SCALE_COEF_REG_OFF};
  int                   fails, n_compared, ev_cnt[9];
  int                   n_sof_out, n_eol_out;

  // Conversion inputs held fixed; Y passthrough and the Y, Cb, Cr conversion with red weight zero are checked
  assign red_weight_coef  = 32'h0;
  assign luma_offset      = 8'h00;
  assign red_diff_offset  = 8'h00;
  assign blue_diff_offset = 8'h00;

  csc_event_and_coef_regs i_dut (.*);
  csc_stream_sink i_sink (.*);

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  always @(posedge mclk)
    for (int i = 0; i < 9; i++)
      if (parallel_event_vector[i] === 1'b1) ev_cnt[i]++;

  // Framing marks must leave with the pixels they came with
  always @(posedge mclk)
    if (m_axis_tvalid === 1'b1 && m_axis_tready === 1'b1) begin
      n_sof_out += m_axis_tuser;
      n_eol_out += m_axis_tlast;
    end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask : chk

  task wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do @(posedge mclk); while (s_axi_awready !== 1'b1 && n++ < 50);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    chk("write ack", {29'h0, 1'b1, er}, {29'h0, s_axi_awready, s_axi_bresp});
  endtask : wr

  task rd(input string nm, input logic [8:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1 && n++ < 50);
    s_axi_arvalid <= 1'b0;
    chk(nm, ex, s_axi_rdata);
    chk("read resp", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
  endtask : rd

  task line(input int cnt, input bit u, input logic [23:0] px = 24'h404040);
    int n;
    for (int i = 0; i < cnt; i++) begin
      n = 0;
      @(posedge mclk);
      s_axis_tdata  <= px;
      s_axis_tuser  <= u && i == 0;
      s_axis_tlast  <= i == cnt - 1;
      s_axis_tvalid <= 1'b1;
      do @(posedge mclk); while (s_axis_tready !== 1'b1 && n++ < 50);
      s_axis_tvalid <= 1'b0;
    end
  endtask : line

  // Pulses land a cycle after the beat, so settle before counting
  task evchk(input logic [8:0] exp);
    logic [8:0] got;
    repeat (4) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      got[i] = ev_cnt[i] != 0;
      ev_cnt[i] = 0;
    end
    chk("events", {23'h0, exp}, {23'h0, got});
  endtask : evchk

  task irqchk(input logic exp);
    repeat (2) @(posedge mclk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : irqchk

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    summarize;
  end

  initial begin
    {resetn, slow, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axis_tvalid, s_axis_tuser, s_axis_tlast, s_axis_tdata} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    s_axi_bready  = 1'b1;
    s_axi_rready  = 1'b1;
    active_width  = 13'h4;
    active_height = 13'h2;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    slow   <= 1'b1;
    line(4, 1'b1);
    line(4, 1'b0);
    evchk(9'h003);
    chk("pixels", 32'h8, {16'h0, n_beats});
    chk("pixel", 32'h40, {8'h0, last_px});
    chk("out sof", 32'h1, n_sof_out);
    chk("out eol", 32'h2, n_eol_out);
    rd("status", CSC_STATUS_OFF, 32'h3, CSC_RESP_OKAY);
    irqchk(1'b0);
    wr(CSC_IRQ_EN_OFF, 32'h2, 4'hF, CSC_RESP_OKAY);
    irqchk(1'b1);
    wr(CSC_STATUS_OFF, 32'h2, 4'hF, CSC_RESP_OKAY);
    irqchk(1'b0);
    rd("status w1c", CSC_STATUS_OFF, 32'h1, CSC_RESP_OKAY);
    line(3, 1'b1);
    evchk(9'h031);
    rd("error", CSC_ERROR_OFF, 32'h1, CSC_RESP_OKAY);
    rd("status err", CSC_STATUS_OFF, 32'h0001_0001, CSC_RESP_OKAY);
    wr(CSC_IRQ_EN_OFF, 32'h0001_0000, 4'hF, CSC_RESP_OKAY);
    irqchk(1'b1);
    wr(CSC_ERROR_OFF, 32'h1, 4'hF, CSC_RESP_OKAY);
    rd("error w1c", CSC_ERROR_OFF, 32'h0, CSC_RESP_OKAY);
    line(6, 1'b1);
    evchk(9'h0D1);
    rd("error late", CSC_ERROR_OFF, 32'h6, CSC_RESP_OKAY);
    line(4, 1'b1);
    line(4, 1'b0);
    line(4, 1'b0);
    evchk(9'h193);
    rd("error sof", CSC_ERROR_OFF, 32'hE, CSC_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      rd("coef reset", coef_a[k], 32'h0, CSC_RESP_OKAY);
      wr(coef_a[k], 32'h0001_2345 + k, 4'hF, CSC_RESP_OKAY);
      wr(coef_a[k], 32'hFFFF_FFFF, 4'h4, CSC_RESP_OKAY);
      rd("coef", coef_a[k], 32'h00FF_2345 + k, CSC_RESP_OKAY);
    end
    // Coefs 0.5, 0.5 and 1.0 in the 65536 scale
    wr(CSC_BLUE_WEIGHT_COEF_REG_OFF, 32'h0000_8001, 4'hF, CSC_RESP_OKAY);
    wr(CSC_RED_DIFF_SCALE_COEF_REG_OFF, 32'h0000_8001, 4'hF, CSC_RESP_OKAY);
    wr(CSC_BLUE_DIFF_SCALE_COEF_REG_OFF, 32'h0001_0001, 4'hF, CSC_RESP_OKAY);
    line(1, 1'b1, 24'hC08040);
    evchk(9'h031);
    chk("pixel conv", 32'h0030_2060, {8'h0, last_px});
    rd("unmapped", 9'h1FC, 32'h0, CSC_RESP_SLVERR);
    wr(9'h1FC, 32'hFFFF_FFFF, 4'hF, CSC_RESP_SLVERR);
    summarize;
  end
endmodule : csc_event_and_coef_regs_test

// ==== verif/csc_regs_asserts.sv ====
`timescale 1ns/1ps
module csc_regs_asserts
  import csc_pkg::*;
(
  input wire logic                 mclk,
  input wire logic                 resetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axis_tvalid,
  input wire logic                 s_axis_tready,
  input wire logic                 s_axis_tuser,
  input wire logic [CSC_PIX_W-1:0] m_axis_tdata,
  input wire logic                 m_axis_tvalid,
  input wire logic                 m_axis_tready,
  input wire logic [CSC_EVT_W-1:0] parallel_event_vector
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence wr_req; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready; endsequence
  sequence wr_ack; s_axi_awready && s_axi_wready && s_axi_bvalid; endsequence
  sequence rd_req; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready; endsequence
  sequence rd_ack; s_axi_arready && s_axi_rvalid; endsequence
  wr_answer_a: assert property (wr_req |=> wr_ack)
    else $error("write not answered");
  rd_answer_a: assert property (rd_req |=> rd_ack)
    else $error("read not answered");
  ready_pulse_a: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
    else $error("write ready not a single pulse");
  evt_reserved_a: assert property (parallel_event_vector[3:2] == 2'b00)
    else $error("reserved event bits set");
  evt_any_err_a: assert property (|parallel_event_vector[8:5] |-> parallel_event_vector[4])
    else $error("stream error bit missing");
  evt_nolatch_a: assert property (parallel_event_vector[0] |=> !parallel_event_vector[0])
    else $error("start event latched");
  start_evt_a: assert property (s_axis_tvalid && s_axis_tready && s_axis_tuser
    |=> parallel_event_vector[0]) else $error("start event missing");
  out_hold_a: assert property (m_axis_tvalid && !m_axis_tready
    |=> m_axis_tvalid && $stable(m_axis_tdata)) else $error("output not held");
  out_follow_a: assert property (s_axis_tvalid && s_axis_tready
    && (!m_axis_tvalid || m_axis_tready) |=> m_axis_tvalid) else $error("pixel lost");
endmodule : csc_regs_asserts

bind csc_event_and_coef_regs csc_regs_asserts i_chk (.*);

// ==== verif/csc_stream_sink.sv ====
`timescale 1ns/1ps
module csc_stream_sink
  import csc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 slow,
  input  wire logic [CSC_PIX_W-1:0] m_axis_tdata,
  input  wire logic                 m_axis_tvalid,
  output logic                      m_axis_tready,
  output logic [15:0]               n_beats,
  output logic [CSC_PIX_W-1:0]      last_px
);
  // Stalls every other cycle when slow, so the output stage must hold
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      m_axis_tready <= 1'b0;
    else
      m_axis_tready <= slow ? ~m_axis_tready : 1'b1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n_beats <= 16'h0000;
      last_px <= '0;
    end else if (m_axis_tvalid && m_axis_tready) begin
      n_beats <= n_beats + 16'h0001;
      last_px <= m_axis_tdata;
    end
  end
endmodule : csc_stream_sink
